/* File: plcls_pkg.sv */
package plcls_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  // Clock rate in MHz
  localparam int CLK_MHZ              = 125;
  // Latch timeout in microseconds
  localparam int LATCH_TIMEOUT_US     = 500;
  // Off timeout in microseconds
  localparam int OFF_TIMEOUT_US       = 500;
  // Soft-start time in microseconds
  localparam int SOFT_START_US        = 300;
  // Cycle counts derived from the times (longest time, round down)
  localparam int LATCH_TIMEOUT_CYC    = LATCH_TIMEOUT_US * CLK_MHZ;
  localparam int OFF_TIMEOUT_CYC      = OFF_TIMEOUT_US * CLK_MHZ;
  localparam int SOFT_START_CYC       = SOFT_START_US * CLK_MHZ;

  // ==========================================================
  // Edge counts and addresses
  // ==========================================================
  localparam logic [4:0] EDGE_DATA_MIN = 5'h01;
  localparam logic [4:0] EDGE_DATA_MAX = 5'h10;
  localparam logic [4:0] EDGE_ADDR_MIN = 5'h11;
  localparam logic [4:0] EDGE_ADDR_MAX = 5'h15;
  localparam logic [4:0] EDGE_SAT      = 5'h1f;

  // Register addresses
  localparam logic [2:0] ADDR_BACKLIGHT_LEVEL = 3'h0;
  localparam logic [2:0] ADDR_AUX_LEVEL       = 3'h1;
  localparam logic [2:0] ADDR_BACKLIGHT_ONOFF = 3'h2;
  localparam logic [2:0] ADDR_AUX_ONOFF       = 3'h3;
  localparam logic [2:0] ADDR_ALL_ON          = 3'h4;

  // Reset value of every data register
  localparam logic [3:0] REG_RESET = 4'h0;

  // ==========================================================
  // Types
  // ==========================================================
  // Five sink enables, grouped
  typedef struct packed {
    logic backlight_sink_first;
    logic backlight_sink_second;
    logic auxiliary_sink_first;
    logic auxiliary_sink_second;
    logic auxiliary_sink_third;
  } plcls_sinks_s;

  // Analog fault and supply indications
  typedef struct packed {
    logic current_over_limit;
    logic over_temperature;
    logic overvolt_sense_input;
    logic supply_low_lockout;
  } plcls_faults_s;

  // Power sequencing states
  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_SOFT_START,
    PWR_RUN
  } plcls_pwr_e;

endpackage

/* File: plcls_timer.sv */
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Level-duration timer: fires once the level stays for LIMIT
// ============================================================
module plcls_timer #(
  parameter int LIMIT = 62500
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // Level being timed and restart
  input  wire logic level_in,
  input  wire logic restart_in,
  // One-cycle pulse when LIMIT reached
  output logic      expire_out
);

  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] count_q;  // Cycles the level has stood
  logic         done_q;   // Already fired for this stretch

  // Count while level holds; fire once per stretch
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_q    <= '0;
      done_q     <= 1'b0;
      expire_out <= 1'b0;
    end
    else if (!level_in || restart_in)
    begin
      count_q    <= '0;
      done_q     <= 1'b0;
      expire_out <= 1'b0;
    end
    else if (!done_q && count_q == LIM - W'(1))
    begin
      // Saturate; a long stretch fires only once
      count_q    <= LIM;
      done_q     <= 1'b1;
      expire_out <= 1'b1;
    end
    else
    begin
      if (!done_q)
        count_q <= count_q + W'(1);
      expire_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: plcls_core.sv */
`timescale 1ns/100ps
`default_nettype none

module plcls_core
  import plcls_pkg::*;
#(
  parameter int LATCH_CYC = plcls_pkg::LATCH_TIMEOUT_CYC,
  parameter int OFF_CYC   = plcls_pkg::OFF_TIMEOUT_CYC,
  parameter int SS_CYC    = plcls_pkg::SOFT_START_CYC
) (
  // Clock and reset
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  // Single control pin
  input  wire logic                     ctrl_pin_in,
  // Analog condition indications
  input  wire plcls_pkg::plcls_faults_s faults_in,
  // Sink enables and levels
  output plcls_pkg::plcls_sinks_s       sinks_on_out,
  output logic [3:0]                    backlight_level_out,
  output logic [3:0]                    auxiliary_level_out,
  output logic [6:0]                    backlight_pct_x2_out,
  output logic [6:0]                    auxiliary_pct_x2_out,
  // Power stage controls
  output logic                          disconnect_en_out,
  output logic                          soft_start_out,
  output logic                          switch_en_out,
  output logic                          shutdown_out
);

  import plcls_pkg::*;

  // ==========================================================
  // Pin synchroniser and edge detect
  // ==========================================================
  logic       sync1_q;    // First stage, read only by second
  logic       sync2_q;    // Stable pin level
  logic       pin_q;      // Delayed level for edge detect
  logic       rise;       // Rising edge this cycle
  logic       latch_hit;  // Latch timeout pulse
  logic       off_hit;    // Off timeout pulse

  // Two-flop synchroniser of the control pin
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      pin_q   <= 1'b0;
    end
    else
    begin
      sync1_q <= ctrl_pin_in;
      sync2_q <= sync1_q;
      pin_q   <= sync2_q;
    end
  end

  assign rise = sync2_q && !pin_q;

  // ==========================================================
  // Timeouts
  // ==========================================================
  // High time after a burst; restarts on every new edge
  plcls_timer #(.LIMIT(LATCH_CYC)) u_latch_timer (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .level_in   (sync2_q),
    .restart_in (rise),
    .expire_out (latch_hit)
  );

  // Low time for shutdown
  plcls_timer #(.LIMIT(OFF_CYC)) u_off_timer (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .level_in   (!sync2_q),
    .restart_in (1'b0),
    .expire_out (off_hit)
  );

  // ==========================================================
  // Edge counter
  // ==========================================================
  logic [4:0] edges_q;  // Rising edges in current burst
  logic       shut_q;   // Shutdown state

  // Count edges, saturating so huge bursts stay discardable
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      edges_q <= '0;
    else if (off_hit || latch_hit)
      edges_q <= '0;
    else if (rise && edges_q != EDGE_SAT)
      edges_q <= edges_q + 5'h01;
  end

  // ==========================================================
  // Address and data registers
  // ==========================================================
  logic       addr_valid_q;  // An address latched since shutdown
  logic [2:0] addr_q;        // Selected address
  logic [3:0] bl_level_q;    // Backlight group level
  logic [3:0] aux_level_q;   // Auxiliary group level
  logic [3:0] bl_onoff_q;    // Backlight on/off pattern
  logic [3:0] aux_onoff_q;   // Auxiliary on/off pattern
  logic       all_on_q;      // All-on override selected
  logic       is_addr;       // Latched count is an address
  logic       is_data;       // Latched count is data
  logic [3:0] data_code;     // Count minus one, register code

  assign is_addr = edges_q >= EDGE_ADDR_MIN && edges_q <= EDGE_ADDR_MAX;
  assign is_data = edges_q >= EDGE_DATA_MIN && edges_q <= EDGE_DATA_MAX;
  // Codes 1..16 stored as 0..15 so four bits suffice
  assign data_code = 4'(edges_q - 5'h01);

  // Address latch; kept for repeated data writes
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      addr_valid_q <= 1'b0;
      addr_q       <= '0;
      all_on_q     <= 1'b0;
    end
    else if (off_hit)
    begin
      addr_valid_q <= 1'b0;
      addr_q       <= '0;
      all_on_q     <= 1'b0;
    end
    else if (latch_hit && is_addr)
    begin
      // Count 17 is address 0, one per extra edge
      addr_valid_q <= 1'b1;
      addr_q       <= 3'(edges_q - EDGE_ADDR_MIN);
      // No data burst needed for the all-on address
      all_on_q     <= (3'(edges_q - EDGE_ADDR_MIN)
                       == ADDR_ALL_ON);
    end
    // Counts above 21 and zero fall through untouched
  end

  // Data write to the currently selected register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bl_level_q  <= REG_RESET;
      aux_level_q <= REG_RESET;
      bl_onoff_q  <= REG_RESET;
      aux_onoff_q <= REG_RESET;
    end
    else if (off_hit)
    begin
      bl_level_q  <= REG_RESET;
      aux_level_q <= REG_RESET;
      bl_onoff_q  <= REG_RESET;
      aux_onoff_q <= REG_RESET;
    end
    else if (latch_hit && is_data && addr_valid_q)
    begin
      case (addr_q)
        ADDR_BACKLIGHT_LEVEL: bl_level_q  <= data_code;
        ADDR_AUX_LEVEL:       aux_level_q <= data_code;
        ADDR_BACKLIGHT_ONOFF: bl_onoff_q  <= data_code;
        ADDR_AUX_ONOFF:       aux_onoff_q <= data_code;
        default:              ;  // All-on address takes no data
      endcase
    end
  end

  // ==========================================================
  // Shutdown and power sequencing
  // ==========================================================
  plcls_pwr_e pwr_q;      // Power sequencing state
  logic [$clog2(SS_CYC+1)-1:0] ss_cnt_q;  // Soft-start cycles
  logic       lockout;    // Supply too low
  logic       fault_stop; // Current, temperature or overvoltage stop

  assign lockout    = faults_in.supply_low_lockout;
  // Comparators carry their own hysteresis; fault level is not latched
  assign fault_stop = faults_in.current_over_limit
                    || faults_in.over_temperature
                    || faults_in.overvolt_sense_input;

  // Shutdown flag: set on long low, left when pin is high and supply not locked out
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      shut_q <= 1'b1;
    else if (off_hit)
      shut_q <= 1'b1;
    else if (sync2_q && !lockout)
      shut_q <= 1'b0;
  end

  // Off, soft-start, run sequence
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pwr_q    <= PWR_OFF;
      ss_cnt_q <= '0;
    end
    else if (lockout || off_hit)
    begin
      pwr_q    <= PWR_OFF;
      ss_cnt_q <= '0;
    end
    else
    begin
      case (pwr_q)
        PWR_OFF:
        begin
          ss_cnt_q <= '0;
          if (sync2_q)
            pwr_q <= PWR_SOFT_START;
        end
        PWR_SOFT_START:
        begin
          if (ss_cnt_q == ($clog2(SS_CYC+1))'(SS_CYC - 1))
            pwr_q <= PWR_RUN;
          else
            ss_cnt_q <= ss_cnt_q + 1'b1;
        end
        PWR_RUN:
          pwr_q <= PWR_RUN;
        default:
          pwr_q <= PWR_OFF;
      endcase
    end
  end

  // ==========================================================
  // Output decode
  // ==========================================================
  plcls_sinks_s sinks_d;  // Next sink enables

  // Sink pattern decode
  always_comb
  begin
    sinks_d = '0;
    // Backlight: code1 off, 2 second, 3 first, 4 both
    case (bl_onoff_q)
      4'h1: sinks_d.backlight_sink_second = 1'b1;
      4'h2: sinks_d.backlight_sink_first  = 1'b1;
      4'h3:
      begin
        sinks_d.backlight_sink_first  = 1'b1;
        sinks_d.backlight_sink_second = 1'b1;
      end
      default: ;
    endcase
    // Auxiliary: stored codes 0..7 are the binary pattern, higher codes all off
    if (aux_onoff_q <= 4'h7)
    begin
      sinks_d.auxiliary_sink_first  = aux_onoff_q[2];
      sinks_d.auxiliary_sink_second = aux_onoff_q[1];
      sinks_d.auxiliary_sink_third  = aux_onoff_q[0];
    end
    if (all_on_q)
      sinks_d = '1;
    if (shut_q || pwr_q != PWR_RUN)
      sinks_d = '0;
  end

  // Registered outputs
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sinks_on_out         <= '0;
      backlight_level_out  <= '0;
      auxiliary_level_out  <= '0;
      backlight_pct_x2_out <= '0;
      auxiliary_pct_x2_out <= '0;
      disconnect_en_out    <= 1'b0;
      soft_start_out       <= 1'b0;
      switch_en_out        <= 1'b0;
      shutdown_out         <= 1'b1;
    end
    else
    begin
      sinks_on_out         <= sinks_d;
      backlight_level_out  <= bl_level_q;
      auxiliary_level_out  <= aux_level_q;
      backlight_pct_x2_out <= pct2_of(bl_level_q);
      auxiliary_pct_x2_out <= pct2_of(aux_level_q);
      // Over temperature opens the input switch as well
      disconnect_en_out    <= pwr_q != PWR_OFF
                              && !faults_in.over_temperature;
      soft_start_out       <= pwr_q == PWR_SOFT_START;
      switch_en_out        <= pwr_q == PWR_RUN && !fault_stop
                              && !shut_q;
      shutdown_out         <= shut_q;
    end
  end

  // Percent times two: 100,84..15 then 13.5,12,10.5,9
  function automatic logic [7:0] pct2_full(input logic [3:0] code);
    logic [7:0] v;
    case (code)
      4'h0: v = 8'hc8;
      4'h1: v = 8'ha8;
      4'h2: v = 8'h8e;
      4'h3: v = 8'h78;
      4'h4: v = 8'h66;
      4'h5: v = 8'h56;
      4'h6: v = 8'h46;
      4'h7: v = 8'h3e;
      4'h8: v = 8'h34;
      4'h9: v = 8'h2a;
      4'ha: v = 8'h24;
      4'hb: v = 8'h1e;
      4'hc: v = 8'h1b;
      4'hd: v = 8'h18;
      4'he: v = 8'h15;
      default: v = 8'h12;
    endcase
    return v;
  endfunction

  // Halved to seven bits: percent rounded down
  function automatic logic [6:0] pct2_of(input logic [3:0] code);
    logic [7:0] v;
    v = pct2_full(code);
    return v[7:1];
  endfunction

endmodule

`default_nettype wire

/* File: plcls_core_chk.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Port checker for the single-pin sink control
// ==========================================================
module plcls_core_chk
  import plcls_pkg::*;
#(
  parameter int LATCH_CYC = 50,
  parameter int OFF_CYC   = 50
) (
  // Clock and reset
  input wire logic                     clock_in,
  input wire logic                     rst_in,
  // Inputs watched
  input wire logic                     ctrl_pin_in,
  input wire plcls_pkg::plcls_faults_s faults_in,
  // Outputs watched
  input wire plcls_pkg::plcls_sinks_s  sinks_on_out,
  input wire logic [3:0]               backlight_level_out,
  input wire logic [3:0]               auxiliary_level_out,
  input wire logic                     disconnect_en_out,
  input wire logic                     soft_start_out,
  input wire logic                     switch_en_out,
  input wire logic                     shutdown_out
);
  import plcls_pkg::*;

  int hi_cnt; // Consecutive high samples
  int lo_cnt; // Consecutive low samples

  // Pin level durations; saturate so long idles cannot wrap
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hi_cnt <= 0;
      lo_cnt <= 0;
    end
    else
    begin
      hi_cnt <= !ctrl_pin_in ? 0 : (hi_cnt < 99999 ? hi_cnt + 1 : hi_cnt);
      lo_cnt <= ctrl_pin_in ? 0 : (lo_cnt < 99999 ? lo_cnt + 1 : lo_cnt);
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // ==========================================================
  // Assertions
  // ==========================================================
  sinks_off_shut_a: assert property (shutdown_out |->
    sinks_on_out == '0)
    else $error("sink on during shutdown");
  shut_noswitch_a: assert property (shutdown_out |->
    !switch_en_out)
    else $error("switching during shutdown");
  ilim_stop_a: assert property (
    faults_in.current_over_limit [*3] |-> !switch_en_out)
    else $error("switching over current limit");
  otemp_stop_a: assert property (
    faults_in.over_temperature [*3] |-> !switch_en_out)
    else $error("switching over temperature");
  otemp_disc_a: assert property (
    faults_in.over_temperature [*3] |-> !disconnect_en_out)
    else $error("input switch on over temperature");
  ovolt_stop_a: assert property (
    faults_in.overvolt_sense_input [*3] |-> !switch_en_out)
    else $error("switching over voltage");
  lockout_hold_a: assert property (
    faults_in.supply_low_lockout [*3] |->
    !soft_start_out && !switch_en_out)
    else $error("activity under lockout");
  ss_before_sw_a: assert property (soft_start_out |->
    !switch_en_out)
    else $error("switching during soft start");
  off_timeout_a: assert property (lo_cnt > OFF_CYC + 4 |->
    shutdown_out)
    else $error("no shutdown after long low");
  shut_clear_a: assert property (
    shutdown_out && $past(shutdown_out) |->
    backlight_level_out == 4'h0 && auxiliary_level_out == 4'h0)
    else $error("level held in shutdown");
  latch_wait_a: assert property ($changed(backlight_level_out) |->
    hi_cnt >= LATCH_CYC || lo_cnt >= OFF_CYC)
    else $error("level changed before latch timeout");

  // Main scenarios reached
  cover property (sinks_on_out == 5'h1f);
  cover property ($rose(shutdown_out));
  cover property (switch_en_out && $past(soft_start_out));
endmodule

bind plcls_core plcls_core_chk #(
  .LATCH_CYC(LATCH_CYC),
  .OFF_CYC  (OFF_CYC)
) plcls_core_chk_inst (
  .clock_in           (clock_in),
  .rst_in             (rst_in),
  .ctrl_pin_in        (ctrl_pin_in),
  .faults_in          (faults_in),
  .sinks_on_out       (sinks_on_out),
  .backlight_level_out(backlight_level_out),
  .auxiliary_level_out(auxiliary_level_out),
  .disconnect_en_out  (disconnect_en_out),
  .soft_start_out     (soft_start_out),
  .switch_en_out      (switch_en_out),
  .shutdown_out       (shutdown_out)
);

`default_nettype wire

/* File: plcls_host.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Host model driving the single control pin
// ==========================================================
module plcls_host #(
  parameter int LATCH_CYC = 50
) (
  // Clock
  input  wire logic clock_in,
  // Control pin
  output logic      ctrl_pin_out
);
  // Pin low at start, device sits in shutdown
  initial ctrl_pin_out = 1'b0;

  // Burst of n edges, low 2 cycles each, then long high
  task automatic burst(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock_in);
      ctrl_pin_out <= 1'b0;
      repeat (2) @(posedge clock_in);
      ctrl_pin_out <= 1'b1;
      @(posedge clock_in);
    end
    // Margin covers sync, latch and output stages
    repeat (LATCH_CYC + 8) @(posedge clock_in);
  endtask

  // Hold the pin at a level for a number of cycles
  task automatic hold(input logic lvl, input int cyc);
    @(posedge clock_in);
    ctrl_pin_out <= lvl;
    repeat (cyc) @(posedge clock_in);
  endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Testbench for the single-pin sink control
// ==========================================================
module tb_top;
  import plcls_pkg::*;
  localparam int LAT = 50; // Shortened latch timeout
  localparam int OFF = 50; // Shortened off timeout
  localparam int SS  = 20; // Shortened soft start
  logic          clock_in = 1'b0;
  logic          rst_in   = 1'b1;
  logic          ctrl_pin;
  plcls_faults_s faults   = '0;
  plcls_sinks_s  sinks;
  logic [3:0]    bl_lvl;
  logic [3:0]    aux_lvl;
  logic [6:0]    bl_pct;
  logic [6:0]    aux_pct;
  logic          ss_on;
  logic          sw_en;
  logic          shut;
  logic          disc;
  int            num_errors   = 0;
  int            total_checks = 0;
  // Expected floor percent per stored level
  logic [6:0]    pct_tab [16] = '{7'h64, 7'h54, 7'h47, 7'h3c, 7'h33,
    7'h2b, 7'h23, 7'h1f, 7'h1a, 7'h15, 7'h12, 7'h0f, 7'h0d, 7'h0c,
    7'h0a, 7'h09};

  always #4 clock_in = ~clock_in;

  plcls_core #(.LATCH_CYC(LAT), .OFF_CYC(OFF), .SS_CYC(SS)) plcls_core_inst (
    .clock_in            (clock_in),
    .rst_in              (rst_in),
    .ctrl_pin_in         (ctrl_pin),
    .faults_in           (faults),
    .sinks_on_out        (sinks),
    .backlight_level_out (bl_lvl),
    .auxiliary_level_out (aux_lvl),
    .backlight_pct_x2_out(bl_pct),
    .auxiliary_pct_x2_out(aux_pct),
    .disconnect_en_out   (disc),
    .soft_start_out      (ss_on),
    .switch_en_out       (sw_en),
    .shutdown_out        (shut)
  );

  plcls_host #(.LATCH_CYC(LAT)) plcls_host_inst (
    .clock_in    (clock_in),
    .ctrl_pin_out(ctrl_pin)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  // Compare one value, count and report
  task automatic chk(input string name, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask

  // Let edges pass, then sample after updates land
  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic close_out();
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic test_reset();
    #1;
    chk("shutdown", 8'h01, shut);
    chk("sinks", 8'h00, sinks);
    chk("bl_level", 8'h00, bl_lvl);
    chk("switch", 8'h00, sw_en);
    chk("disconnect", 8'h00, disc);
  endtask

  // Backlight addressed once, every level code by data only; then aux
  task automatic test_levels();
    plcls_host_inst.burst(17);
    chk("switch", 8'h01, sw_en);
    chk("disconnect", 8'h01, disc);
    for (int c = 1; c <= 16; c++)
    begin
      plcls_host_inst.burst(c);
      chk("bl_level", 8'(c - 1), bl_lvl);
      chk("bl_pct", pct_tab[c - 1], bl_pct);
    end
    plcls_host_inst.burst(18);
    plcls_host_inst.burst(16);
    chk("aux_level", 8'h0f, aux_lvl);
    chk("aux_pct", 8'h09, aux_pct);
  endtask

  // On/off codes 1..4 of the backlight group and 1..8 of the auxiliary group
  task automatic test_patterns();
    plcls_host_inst.burst(19);
    for (int c = 1; c <= 4; c++)
    begin
      plcls_host_inst.burst(c);
      chk("bl_sinks", 8'(c - 1), {sinks.backlight_sink_first,
        sinks.backlight_sink_second});
    end
    plcls_host_inst.burst(20);
    for (int c = 1; c <= 8; c++)
    begin
      plcls_host_inst.burst(c);
      chk("aux_sinks", 8'(c - 1), sinks[2:0]);
    end
  endtask

  // Reset in mid-run clears all; pin high at release gives
  // a lone edge that must be dropped as orphan data
  task automatic test_midreset();
    @(posedge clock_in);
    rst_in <= 1'b1;
    settle(2);
    chk("shutdown", 8'h01, shut);
    chk("sinks", 8'h00, sinks);
    chk("aux_level", 8'h00, aux_lvl);
    chk("disconnect", 8'h00, disc);
    @(posedge clock_in);
    rst_in <= 1'b0;
    plcls_host_inst.hold(1'b1, LAT + 8);
    plcls_host_inst.burst(2);
    chk("bl_level", 8'h00, bl_lvl);
    chk("switch", 8'h01, sw_en);
  endtask

  // All-on address, then an over-range count is dropped
  task automatic test_all_on();
    plcls_host_inst.burst(21);
    chk("sinks", 8'h1f, sinks);
    plcls_host_inst.burst(19);
    plcls_host_inst.burst(22);
    plcls_host_inst.burst(1);
    chk("bl_sinks", 8'h00, {sinks.backlight_sink_first,
      sinks.backlight_sink_second});
  endtask

  // Each fault stops switching; lockout restarts soft start
  task automatic test_faults();
    for (int i = 1; i <= 3; i++)
    begin
      @(posedge clock_in);
      faults <= 4'h1 << i;
      settle(4);
      chk("switch", 8'h00, sw_en);
      chk("disconnect", (i == 2) ? 8'h00 : 8'h01, disc);
      @(posedge clock_in);
      faults <= '0;
      settle(4);
      chk("switch", 8'h01, sw_en);
      chk("disconnect", 8'h01, disc);
    end
    @(posedge clock_in);
    faults <= 4'h1;
    settle(4);
    chk("soft_start", 8'h00, ss_on);
    chk("switch", 8'h00, sw_en);
    chk("disconnect", 8'h00, disc);
    @(posedge clock_in);
    faults <= '0;
    settle(4);
    chk("soft_start", 8'h01, ss_on);
    settle(SS + 4);
    chk("switch", 8'h01, sw_en);
  endtask

  // Long low clears all; orphan data afterwards ignored
  task automatic test_shutdown();
    plcls_host_inst.hold(1'b0, OFF + 10);
    #1;
    chk("shutdown", 8'h01, shut);
    chk("bl_level", 8'h00, bl_lvl);
    chk("aux_level", 8'h00, aux_lvl);
    chk("sinks", 8'h00, sinks);
    plcls_host_inst.hold(1'b1, 4);
    plcls_host_inst.burst(5);
    chk("shutdown", 8'h00, shut);
    chk("bl_level", 8'h00, bl_lvl);
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clock_in);
    test_reset();
    @(posedge clock_in);
    rst_in <= 1'b0;
    test_levels();
    test_patterns();
    test_midreset();
    test_all_on();
    test_faults();
    test_shutdown();
    close_out();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (40000) @(posedge clock_in);
    num_errors++;
    close_out();
  end
endmodule

`default_nettype wire
